// File: core/scbc_clock_calendar.sv
// Purpose: two-wire slave clock/calendar with a 64 x 8 array
// Assumes: scl, sdaIn, oscIn synchronous to sys_clk
// Notes: sda and reset output are open drain, oe high pulls low
`timescale 1ns/10ps
`default_nettype none

// What this block does
// [RULE_01] A 64-word by 8-bit array holds time, control and user bytes.
// [RULE_02] Timekeeping is paced by the 32.768 kHz crystal oscillator.
// [RULE_03] Eight array bytes hold the clock counters, all in BCD.
// [RULE_04] Twelve further bytes are kept for alarm, watchdog, square wave.
// [RULE_05] Word address and data move serially over the two-wire bus.
// [RULE_06] The word address advances by one after each data byte.
// [RULE_07] Counters hold century to hundredths, hours in 24-hour BCD form.
// [RULE_08] Dates roll at 28, 29, 30 or 31 days, leap years through 2100.
// [RULE_09] The ninth location holds access control and calibration.
// [RULE_10] The reset output asserts at power-on and on the reset request.
// [RULE_11] The slave answers only to address D0h after a start.
// [RULE_12] The 64 locations follow the fixed time, control, RAM order.
// [RULE_13] Time copy into readable bytes halts while clock bytes are read.
// [RULE_14] On reads the pointer advances only after the master's ack.
// [RULE_15] A 100 Hz tick drives hundredths, each counter carrying upward.
module scbc_clock_calendar #(
  parameter int POR_CYCLES = scbc_pkg::POR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic oscIn,
  input wire logic externalResetRequestInN,
  output logic rstOut,
  output logic rstOutOe
);

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  // returns {wrap, next}; wrap only when enabled and at or above the top value
  function automatic logic [8:0] bcdStep(input logic [7:0] v,
      input logic [7:0] top, input logic [7:0] bot, input logic en);
    logic [8:0] r;
    r = {1'b0, v};
    if (en) begin
      if (v >= top) begin
        r = {1'b1, bot};
      end else begin
        r = {1'b0, bcdInc(v)};
      end
    end
    return r;
  endfunction

  // mod-4 test on BCD year; year 00 counts as leap, right through 2100
  function automatic logic [7:0] monthDays(input logic [7:0] mon,
      input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: r = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  logic [7:0] mem [scbc_pkg::ARRAY_DEPTH]; // RULE_01
  logic [7:0] rt [scbc_pkg::CLOCK_BYTES];
  logic [7:0] next_rt [scbc_pkg::CLOCK_BYTES];
  scbc_pkg::scbc_link_type link;
  scbc_pkg::scbc_link_type next_link;
  logic sclPrev;
  logic sdaPrev;
  logic oscPrev;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic tick;
  logic [15:0] porCnt;
  logic [15:0] next_porCnt;
  logic next_rstOutOe;
  logic memWe;
  logic [5:0] memWa;
  logic [7:0] memWd;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic halt;

  assign sclRise = scl && !sclPrev;
  assign sclFall = !scl && sclPrev;
  assign startCond = scl && sclPrev && sdaPrev && !sdaIn; // RULE_05
  assign stopCond = scl && sclPrev && !sdaPrev && sdaIn;
  assign halt = mem[scbc_pkg::ADDR_CTRL][scbc_pkg::CTRL_HALT_BIT]; // RULE_09
  assign sdaOut = 1'b0;
  assign sdaOe = link.sdaOe;
  assign rstOut = 1'b0;

  // fractional divider: exact 100 Hz average, no drift from 327.68
  always_comb begin
    logic [16:0] sum;
    sum = {1'b0, acc} + scbc_pkg::TICK_HZ;
    tick = 1'b0;
    next_acc = acc;
    if (oscIn && !oscPrev) begin // RULE_02
      if (sum >= scbc_pkg::OSC_HZ) begin
        tick = 1'b1; // RULE_15
        next_acc = 16'(sum - scbc_pkg::OSC_HZ);
      end else begin
        next_acc = sum[15:0];
      end
    end
  end

  always_comb begin
    logic [8:0] s;
    logic c;
    logic dayWrap;
    s = 9'h000;
    c = 1'b0;
    dayWrap = 1'b0;
    for (int i = 0; i < scbc_pkg::CLOCK_BYTES; i++) begin
      next_rt[i] = rt[i];
    end
    s = bcdStep(rt[0], 8'h99, 8'h00, tick && !halt); // RULE_15
    next_rt[0] = s[7:0];
    c = s[8];
    s = bcdStep(rt[1], 8'h59, 8'h00, c);
    next_rt[1] = s[7:0];
    c = s[8];
    s = bcdStep(rt[2], 8'h59, 8'h00, c);
    next_rt[2] = s[7:0];
    c = s[8];
    s = bcdStep({2'b00, rt[3][5:0]}, 8'h23, 8'h00, c); // RULE_07
    next_rt[3][5:0] = s[5:0];
    dayWrap = s[8];
    s = bcdStep(rt[4], 8'h07, 8'h01, dayWrap);
    next_rt[4] = s[7:0];
    s = bcdStep(rt[5], monthDays(rt[6], rt[7]), 8'h01, dayWrap); // RULE_08
    next_rt[5] = s[7:0];
    c = s[8];
    s = bcdStep(rt[6], 8'h12, 8'h01, c);
    next_rt[6] = s[7:0];
    c = s[8];
    s = bcdStep(rt[7], 8'h99, 8'h00, c);
    next_rt[7] = s[7:0];
    if (s[8] && rt[3][scbc_pkg::HOUR_CENT_EN_BIT]) begin // RULE_07
      next_rt[3][scbc_pkg::HOUR_CENT_BIT] =
        !rt[3][scbc_pkg::HOUR_CENT_BIT];
    end
    // a host write to a clock byte overrides the running count
    if (memWe && memWa < 6'(scbc_pkg::CLOCK_BYTES)) begin // RULE_03
      next_rt[memWa[2:0]] = memWd;
    end
  end

  always_comb begin
    next_link = link;
    memWe = 1'b0;
    memWa = link.ptr;
    memWd = link.shift;
    if (startCond) begin
      next_link.state = scbc_pkg::ST_RECV;
      next_link.kind = scbc_pkg::KIND_ADDR;
      next_link.cnt = 4'h0;
      next_link.sdaOe = 1'b0;
    end else if (stopCond) begin
      next_link.state = scbc_pkg::ST_IDLE;
      next_link.sdaOe = 1'b0;
      next_link.freeze = 1'b0; // RULE_13
    end else begin
      case (link.state)
        scbc_pkg::ST_RECV: begin
          if (sclRise) begin
            next_link.shift = {link.shift[6:0], sdaIn};
            next_link.cnt = link.cnt + 4'h1;
          end else if (sclFall && link.cnt == scbc_pkg::BITS_PER_BYTE) begin
            next_link.state = scbc_pkg::ST_ACK;
            next_link.sdaOe = 1'b1;
            case (link.kind)
              scbc_pkg::KIND_ADDR: begin
                next_link.rw = link.shift[0];
                if (link.shift[7:1] != scbc_pkg::SLAVE_ADDR) begin // RULE_11
                  next_link.state = scbc_pkg::ST_IDLE;
                  next_link.sdaOe = 1'b0;
                end
              end
              scbc_pkg::KIND_WORD: begin
                next_link.ptr = link.shift[5:0];
              end
              default: begin
                memWe = 1'b1;
                next_link.ptr = link.ptr + 6'h01; // RULE_06
              end
            endcase
          end
        end
        scbc_pkg::ST_ACK: begin
          if (sclFall) begin
            if (link.kind == scbc_pkg::KIND_ADDR && link.rw) begin
              next_link.state = scbc_pkg::ST_SEND;
              next_link.shift = mem[link.ptr];
              next_link.sdaOe = !mem[link.ptr][7];
              next_link.cnt = 4'h1;
              if (link.ptr < 6'(scbc_pkg::CLOCK_BYTES)) begin
                next_link.freeze = 1'b1; // RULE_13
              end
            end else begin
              next_link.state = scbc_pkg::ST_RECV;
              next_link.sdaOe = 1'b0;
              next_link.cnt = 4'h0;
              next_link.kind = (link.kind == scbc_pkg::KIND_ADDR) ?
                scbc_pkg::KIND_WORD : scbc_pkg::KIND_DATA;
            end
          end
        end
        scbc_pkg::ST_SEND: begin
          if (sclFall) begin
            if (link.cnt == scbc_pkg::BITS_PER_BYTE) begin
              next_link.state = scbc_pkg::ST_MACK;
              next_link.sdaOe = 1'b0;
            end else begin
              next_link.shift = {link.shift[6:0], 1'b0};
              next_link.sdaOe = !link.shift[6];
              next_link.cnt = link.cnt + 4'h1;
            end
          end
        end
        scbc_pkg::ST_MACK: begin
          if (sclRise) begin
            if (!sdaIn) begin
              next_link.ptr = link.ptr + 6'h01; // RULE_14
              next_link.state = scbc_pkg::ST_MNEXT;
              if (link.ptr + 6'h01 >= 6'(scbc_pkg::CLOCK_BYTES)) begin
                next_link.freeze = 1'b0; // RULE_13
              end
            end else begin
              // no ack ends the read; line stays released for the stop
              next_link.state = scbc_pkg::ST_IDLE;
            end
          end
        end
        scbc_pkg::ST_MNEXT: begin
          if (sclFall) begin
            next_link.state = scbc_pkg::ST_SEND;
            next_link.shift = mem[link.ptr];
            next_link.sdaOe = !mem[link.ptr][7];
            next_link.cnt = 4'h1;
            if (link.ptr < 6'(scbc_pkg::CLOCK_BYTES)) begin
              next_link.freeze = 1'b1;
            end
          end
        end
        default: begin
          next_link.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_porCnt = porCnt;
    if (porCnt != 16'h0000) begin
      next_porCnt = porCnt - 16'h0001;
    end
    next_rstOutOe = (porCnt != 16'h0000) || !externalResetRequestInN; // RULE_10
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      link <= '0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      oscPrev <= 1'b0;
      acc <= 16'h0000;
      porCnt <= 16'(POR_CYCLES);
      rstOutOe <= 1'b1;
      for (int i = 0; i < scbc_pkg::CLOCK_BYTES; i++) begin
        rt[i] <= scbc_pkg::RESET_BYTE;
      end
      rt[scbc_pkg::ADDR_DAY[2:0]] <= scbc_pkg::RESET_ONE; // RULE_12
      rt[scbc_pkg::ADDR_DATE[2:0]] <= scbc_pkg::RESET_ONE;
      rt[scbc_pkg::ADDR_MONTH[2:0]] <= scbc_pkg::RESET_ONE;
    end else begin
      link <= next_link;
      sclPrev <= scl;
      sdaPrev <= sdaIn;
      oscPrev <= oscIn;
      acc <= next_acc;
      porCnt <= next_porCnt;
      rstOutOe <= next_rstOutOe;
      for (int i = 0; i < scbc_pkg::CLOCK_BYTES; i++) begin
        rt[i] <= next_rt[i];
      end
    end
  end

  // clock bytes mirror the running count unless a read holds them still
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < scbc_pkg::ARRAY_DEPTH; i++) begin
        mem[i] <= scbc_pkg::RESET_BYTE;
      end
    end else begin
      if (!link.freeze) begin
        for (int i = 0; i < scbc_pkg::CLOCK_BYTES; i++) begin
          mem[i] <= rt[i]; // RULE_13
        end
      end
      if (memWe && memWa >= 6'(scbc_pkg::CLOCK_BYTES)) begin
        mem[memWa] <= memWd; // RULE_04
      end
    end
  end

endmodule // scbc_clock_calendar
`default_nettype wire

// File: core/scbc_pkg.sv
// Purpose: shared constants and types for the serial BCD clock/calendar
// Assumes: 25 MHz system clock, 32.768 kHz oscillator sampled as a level
// Notes: all offsets are word addresses into the 64 x 8 array
`default_nettype none
package scbc_pkg;
  localparam int ARRAY_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int CLOCK_BYTES = 8;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam logic [5:0] ADDR_HUND = 6'h00;
  localparam logic [5:0] ADDR_SEC = 6'h01;
  localparam logic [5:0] ADDR_MIN = 6'h02;
  localparam logic [5:0] ADDR_HOUR = 6'h03;
  localparam logic [5:0] ADDR_DAY = 6'h04;
  localparam logic [5:0] ADDR_DATE = 6'h05;
  localparam logic [5:0] ADDR_MONTH = 6'h06;
  localparam logic [5:0] ADDR_YEAR = 6'h07;
  localparam logic [5:0] ADDR_CTRL = 6'h08;
  localparam logic [5:0] ADDR_WDOG = 6'h09;
  localparam logic [5:0] ADDR_ALARM0 = 6'h0A;
  localparam logic [5:0] ADDR_RSVD0 = 6'h10;
  localparam logic [5:0] ADDR_SQW = 6'h13;
  localparam logic [5:0] ADDR_USER0 = 6'h14;
  localparam int CTRL_HALT_BIT = 7;
  localparam int CAL_LSB = 0;
  localparam int CAL_W = 5;
  localparam int HOUR_CENT_BIT = 6;
  localparam int HOUR_CENT_EN_BIT = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_ONE = 8'h01;
  localparam logic [16:0] OSC_HZ = 17'h08000;
  localparam logic [16:0] TICK_HZ = 17'h00064;
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int POR_TIME_US = 200;
  localparam int POR_CYCLES = POR_TIME_US * (SYS_CLK_HZ / 1_000_000);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100,
    ST_MNEXT = 3'b101
  } scbc_state_type;

  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_WORD = 2'b01,
    KIND_DATA = 2'b10
  } scbc_kind_type;

  typedef struct packed {
    scbc_state_type state;
    scbc_kind_type kind;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [5:0] ptr;
    logic sdaOe;
    logic freeze;
  } scbc_link_type;
endpackage
`default_nettype wire

// File: verification/scbc_sva.sv
// Purpose: bus and reset output checks for the clock/calendar slave
// Assumes: one clock domain, scl and sda idle high
// Notes: only the first byte after each start is decoded here
`timescale 1ns/10ps
`default_nettype none
module scbc_sva #(
  parameter int POR_CYCLES = scbc_pkg::POR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic oscIn,
  input wire logic externalResetRequestInN,
  input wire logic rstOut,
  input wire logic rstOutOe
);
  logic [15:0] porC;
  logic [3:0] nb;
  logic [7:0] sh;
  logic inFirst, sclQ, sdaQ;
  wire adDone = inFirst && nb == 4'h8;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      porC <= 16'h0000;
      {sclQ, sdaQ, inFirst, nb, sh} <= {2'b11, 13'h0000};
    end else begin
      if (int'(porC) <= POR_CYCLES) porC <= porC + 16'h0001;
      sclQ <= scl;
      sdaQ <= sdaIn;
      if (scl && sclQ && sdaQ && !sdaIn) begin
        inFirst <= 1'b1;
        nb <= 4'h0;
      end else if (scl && !sclQ && inFirst) begin
        if (nb < 4'h8) begin
          sh <= {sh[6:0], sdaIn};
          nb <= nb + 4'h1;
        end else inFirst <= 1'b0;
      end
    end
  end
  sequence sStop; scl && sclQ && !sdaQ && sdaIn; endsequence
  sequence sAddr; $rose(adDone); endsequence
  por_hold_a: assert property (
    int'(porC) < POR_CYCLES |-> rstOutOe) else $error("reset out early");
  rst_follow_a: assert property (
    int'(porC) > POR_CYCLES |-> rstOutOe == !$past(externalResetRequestInN))
    else $error("reset out not following request");
  out_low_a: assert property (
    !sdaOut && !rstOut) else $error("open drain value not low");
  oe_scl_a: assert property (
    $changed(sdaOe) |-> !sclQ) else $error("sda moved after scl high");
  hold_high_a: assert property (
    scl && sclQ |-> $stable(sdaOe)) else $error("sda moved in scl high");
  addr_ack_a: assert property (
    sAddr ##0 (sh[7:1] == 7'h68) |-> ##[1:12] sdaOe)
    else $error("own address not acknowledged");
  addr_nack_a: assert property (
    sAddr ##0 (sh[7:1] != 7'h68) |-> !sdaOe [*8])
    else $error("foreign address acknowledged");
  stop_free_a: assert property (
    sStop |=> !sdaOe [*4]) else $error("sda held after stop");
endmodule // scbc_sva
bind scbc_clock_calendar scbc_sva #(.POR_CYCLES(POR_CYCLES)) u_sva (
  .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .oscIn(oscIn), .rstOut(rstOut),
  .externalResetRequestInN(externalResetRequestInN), .rstOutOe(rstOutOe));
`default_nettype wire

// File: verification/scbc_master.sv
// Purpose: two-wire bus master model
// Assumes: sda wire is pulled up, master only pulls it low
// Notes: bit slot is eight clocks, no clock stretching
`timescale 1ns/10ps
`default_nettype none
module scbc_master (
  input wire logic clk,
  input wire logic sda,
  output var logic scl,
  output var logic pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves only while scl is low
  task automatic bitIo(input logic b, output logic r);
    tick(1);
    pull <= !b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'b0;
  endtask
  task automatic start();
    tick(1);
    pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(1);
    pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    pull <= 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(ai, ao);
  endtask
endmodule // scbc_master
`default_nettype wire

// File: verification/serial_bcd_clock_calendar_test.sv
// Purpose: self-checking bench for the clock/calendar slave
// Assumes: oscillator runs only in the rollover and halt tests
// Notes: results are compared through a queue by a monitor
`timescale 1ns/10ps
`default_nettype none
module serial_bcd_clock_calendar_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic extN = 1'b1;
  logic osc = 1'b0;
  wire scl, pull, sdaOe, rstOe;
  wire sda = !(sdaOe | pull);
  logic [7:0] expQ[$], gotQ[$], me, mg;
  logic [7:0] dat[3];
  // byte 0 in the low bits: hundredths up to year
  localparam logic [63:0] LEAP_EVE = 64'h2402280723595999;
  localparam logic [63:0] LEAP_DAY = 64'h2402290100000000;
  logic [31:0] rs = 32'h00006FDB;
  int num_errors = 0;
  int samples_checked = 0;
  always #20 sys_clk = ~sys_clk;
  scbc_clock_calendar #(.POR_CYCLES(20)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sdaIn(sda),
    .sdaOut(), .sdaOe(sdaOe), .oscIn(osc), .rstOut(),
    .externalResetRequestInN(extN), .rstOutOe(rstOe));
  scbc_master u_m (.clk(sys_clk), .sda(sda), .scl(scl), .pull(pull));
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic note(input logic [7:0] e, input logic [7:0] g);
    expQ.push_back(e);
    gotQ.push_back(g);
  endtask
  task automatic wr(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic a;
    u_m.xfer(d, 1'b1, q, a);
    note({7'h00, ea}, {7'h00, a});
  endtask
  task automatic rd(input logic [7:0] e, input logic m);
    logic [7:0] q;
    logic a;
    u_m.xfer(8'hFF, m, q, a);
    note(e, q);
  endtask
  // word address write, then repeated start for reading
  task automatic point(input logic [7:0] ad);
    u_m.start();
    wr(8'hD0, 1'b0);
    wr(ad, 1'b0);
    u_m.start();
    wr(8'hD1, 1'b0);
  endtask
  task automatic results();
    // a note never compared counts as a miss
    if (expQ.size() != 0) num_errors++;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // notes are many clocks apart, so one per falling edge keeps up
  always @(negedge sys_clk) begin
    if (gotQ.size() != 0) begin
      mg = gotQ.pop_front();
      me = expQ.pop_front();
      samples_checked++;
      if (mg !== me) begin
        num_errors++;
        $display("BAD t=%0t exp=%h got=%h", $time, me, mg);
      end
    end
  end
  initial begin
    #(40 * 20000);
    num_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1 note(8'h01, {7'h00, rstOe});
    repeat (30) @(posedge sys_clk);
    note(8'h00, {7'h00, rstOe});
    extN <= 1'b0;
    repeat (3) @(posedge sys_clk);
    note(8'h01, {7'h00, rstOe});
    extN <= 1'b1;
    repeat (3) @(posedge sys_clk);
    note(8'h00, {7'h00, rstOe});
    $display("test reset output done");
    point(8'h03);
    rd(8'h00, 1'b0);
    rd(8'h01, 1'b0);
    rd(8'h01, 1'b0);
    rd(8'h01, 1'b1);
    u_m.stop();
    $display("test calendar defaults done");
    u_m.start();
    wr(8'hA0, 1'b1);
    u_m.stop();
    $display("test foreign address done");
    // crosses from the last control byte into user storage
    for (int i = 0; i < 3; i++) dat[i] = rnd();
    u_m.start();
    wr(8'hD0, 1'b0);
    wr(8'h13, 1'b0);
    for (int i = 0; i < 3; i++) wr(dat[i], 1'b0);
    u_m.stop();
    point(8'h13);
    rd(dat[0], 1'b0);
    rd(dat[1], 1'b0);
    rd(dat[2], 1'b1);
    u_m.stop();
    // a refused byte leaves the pointer on the last byte read
    u_m.start();
    wr(8'hD1, 1'b0);
    rd(dat[2], 1'b1);
    u_m.stop();
    $display("test pointer walk done");
    // last hundredth of 28 February in a leap year, then one tick
    u_m.start();
    wr(8'hD0, 1'b0);
    wr(8'h00, 1'b0);
    for (int i = 0; i < 8; i++) wr(LEAP_EVE[8*i +: 8], 1'b0);
    u_m.stop();
    // 400 rising edges from a zero phase hold exactly one tick
    repeat (800) @(posedge sys_clk) osc <= !osc;
    point(8'h00);
    for (int i = 0; i < 8; i++) rd(LEAP_DAY[8*i +: 8], i == 7);
    u_m.stop();
    $display("test calendar rollover done");
    // the next tick falls inside this run, so a live count would read 01
    u_m.start();
    wr(8'hD0, 1'b0);
    wr(8'h08, 1'b0);
    wr(8'h80, 1'b0);
    u_m.stop();
    repeat (800) @(posedge sys_clk) osc <= !osc;
    point(8'h00);
    rd(8'h00, 1'b1);
    u_m.stop();
    $display("test halt bit done");
    repeat (4) @(posedge sys_clk);
    results();
  end
endmodule // serial_bcd_clock_calendar_test
`default_nettype wire
